// [hdl/gevx_core.sv]
// Purpose : Decides per guest event between VM exit and guest delivery
// Assumes : Event inputs are one-cycle pulses synchronous to pclk
// Notes   : Exit or deliver decisions are only made while guest_mode is high and no ack runs; blocking state also tracks during an ack
//
// Implementation choices: the APB interface to the registers and the address map.

`timescale 1ns/100ps

module gevx_core (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        exc_valid,
	input  wire logic [4:0]  exc_vector,
	input  wire logic [31:0] exc_err_code,
	input  wire logic        exc_in_df,
	input  wire logic        guest_interrupt_enable_flag,
	input  wire logic        system_mgmt_mode,
	input  wire logic        instr_retire,
	input  wire logic        enable_interrupts_instr,
	input  wire logic        stack_segment_load_instr,
	input  wire logic        interrupt_return_instr,
	input  wire logic        mgmt_mode_resume_instr,
	input  wire logic        system_mgmt_interrupt,
	input  wire logic        nmi_event,
	input  wire logic        init_event,
	input  wire logic        startup_ipi_event,
	input  wire logic        ext_int_pending,
	output logic             intack_req,
	input  wire logic        intack_done,
	input  wire logic [7:0]  intack_vector,
	output logic             vm_exit,
	output logic             guest_deliver,
	output logic      [7:0]  deliver_vector,
	output logic             host_vector_valid,
	output logic      [7:0]  host_vector,
	output logic             host_if_flag,
	output logic             guest_mode,
	output logic             init_blocked,
	output logic             startup_ipi_blocked
);

	typedef enum logic [1:0] {ST_HOST, ST_GUEST, ST_ACK} gevx_state_t;

	gevx_state_t              state_r;
	gevx_pkg::gevx_ack_tgt_t  ack_tgt_r;
	gevx_pkg::gevx_ctrl_t     ctrl_r;
	gevx_pkg::gevx_intr_t     gst_intr_r;
	gevx_pkg::gevx_intr_t     live_r;
	logic [31:0]              bmap_r;
	logic [31:0]              pf_mask_r;
	logic [31:0]              pf_match_r;
	logic [15:0]              exit_rsn_r;
	logic [31:0]              exit_info_r;
	logic                     host_if_r;
	logic                     vm_exit_r;
	logic                     deliver_r;
	logic [7:0]               deliver_vec_r;
	logic                     host_vec_v_r;
	logic [7:0]               host_vec_r;
	logic [31:0]              prdata_r;

	logic                     wr_en;
	logic                     rd_setup;
	logic                     addr_ok;
	logic                     entry_cmd;
	logic                     hostif_cmd;
	logic                     exc_sel;
	logic                     pf_hit;
	logic                     dec_exit;
	logic                     dec_ack;
	logic                     dec_ext;
	logic                     dec_deliver;
	logic                     dec_guest_ack;
	logic                     dec_nmi_dlv;
	logic [15:0]              dec_rsn;
	logic [7:0]               dec_vec;

	// ---------------------------------------------------------------
	// APB slave
	// ---------------------------------------------------------------

	// Zero wait states: read data is captured in the setup cycle
	always_comb begin
		case (paddr)
			gevx_pkg::GEVX_OFF_CTRL,     gevx_pkg::GEVX_OFF_EXC_BMAP,
			gevx_pkg::GEVX_OFF_PF_MASK,  gevx_pkg::GEVX_OFF_PF_MATCH,
			gevx_pkg::GEVX_OFF_GST_INTR, gevx_pkg::GEVX_OFF_CMD,
			gevx_pkg::GEVX_OFF_STATUS,   gevx_pkg::GEVX_OFF_EXIT_RSN,
			gevx_pkg::GEVX_OFF_EXIT_INFO, gevx_pkg::GEVX_OFF_LIVE_INTR: addr_ok = 1'b1;
			default: addr_ok = 1'b0;
		endcase
	end

	assign pready     = 1'b1;
	assign pslverr    = psel && penable && !addr_ok;
	assign wr_en      = psel && penable && pwrite && addr_ok;
	assign rd_setup   = psel && !penable && !pwrite;
	assign entry_cmd  = wr_en && (paddr == gevx_pkg::GEVX_OFF_CMD)
		&& pwdata[gevx_pkg::GEVX_CMD_ENTRY_BIT];
	assign hostif_cmd = wr_en && (paddr == gevx_pkg::GEVX_OFF_CMD)
		&& pwdata[gevx_pkg::GEVX_CMD_HOSTIF_BIT];
	assign prdata     = prdata_r;

	// Read mux; unmapped addresses read as zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= gevx_pkg::GEVX_RST_WORD;
		end else if (rd_setup) begin
			case (paddr)
				gevx_pkg::GEVX_OFF_CTRL:      prdata_r <= {27'h0, ctrl_r};
				gevx_pkg::GEVX_OFF_EXC_BMAP:  prdata_r <= bmap_r;
				gevx_pkg::GEVX_OFF_PF_MASK:   prdata_r <= pf_mask_r;
				gevx_pkg::GEVX_OFF_PF_MATCH:  prdata_r <= pf_match_r;
				gevx_pkg::GEVX_OFF_GST_INTR:  prdata_r <= {28'h0, gst_intr_r};
				gevx_pkg::GEVX_OFF_STATUS:    prdata_r <= {28'h0, system_mgmt_mode,
					state_r == ST_ACK, host_if_r, state_r == ST_GUEST};
				gevx_pkg::GEVX_OFF_EXIT_RSN:  prdata_r <= {16'h0, exit_rsn_r};
				gevx_pkg::GEVX_OFF_EXIT_INFO: prdata_r <= exit_info_r;
				gevx_pkg::GEVX_OFF_LIVE_INTR: prdata_r <= {28'h0, live_r};
				default:                      prdata_r <= gevx_pkg::GEVX_RST_WORD;
			endcase
		end
	end

	// Control structure fields, writable at any time
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r     <= '0;
			bmap_r     <= gevx_pkg::GEVX_RST_WORD;
			pf_mask_r  <= gevx_pkg::GEVX_RST_WORD;
			pf_match_r <= gevx_pkg::GEVX_RST_WORD;
		end else if (wr_en) begin
			case (paddr)
				gevx_pkg::GEVX_OFF_CTRL:     ctrl_r     <= pwdata[4:0];
				gevx_pkg::GEVX_OFF_EXC_BMAP: bmap_r     <= pwdata;
				gevx_pkg::GEVX_OFF_PF_MASK:  pf_mask_r  <= pwdata;
				gevx_pkg::GEVX_OFF_PF_MATCH: pf_match_r <= pwdata;
				default: ;
			endcase
		end
	end

	// Guest-state interruptibility: exit write-back beats software
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gst_intr_r <= '0;
		end else if (vm_exit_r) begin
			gst_intr_r <= live_r;
		end else if (wr_en && paddr == gevx_pkg::GEVX_OFF_GST_INTR) begin
			gst_intr_r <= pwdata[3:0];
		end
	end

	// ---------------------------------------------------------------
	// Exit or deliver decision
	// ---------------------------------------------------------------

	// Page fault exits when bit set and code matches, or bit clear and not
	assign pf_hit  = (exc_err_code & pf_mask_r) == pf_match_r;
	assign exc_sel = (exc_vector == 5'(gevx_pkg::GEVX_PF_VECTOR))
		? (bmap_r[exc_vector] == pf_hit)
		: bmap_r[exc_vector];

	// Fixed priority: init, startup IPI, exception, NMI, external, window
	always_comb begin
		dec_exit      = 1'b0;
		dec_ack       = 1'b0;
		dec_ext       = 1'b0;
		dec_deliver   = 1'b0;
		dec_guest_ack = 1'b0;
		dec_nmi_dlv   = 1'b0;
		dec_rsn       = gevx_pkg::GEVX_RSN_EXC_NMI;
		dec_vec       = 8'h00;
		if (state_r == ST_GUEST) begin
			if (init_event) begin
				dec_exit = 1'b1;
				dec_rsn  = gevx_pkg::GEVX_RSN_INIT;
			end else if (startup_ipi_event) begin
				dec_exit = 1'b1;
				dec_rsn  = gevx_pkg::GEVX_RSN_STARTUP;
			end else if (exc_valid) begin
				if (exc_sel) begin
					dec_exit = 1'b1;
				end else if (exc_in_df) begin
					dec_exit = 1'b1;
					dec_rsn  = gevx_pkg::GEVX_RSN_TRIPLE;
				end else begin
					dec_deliver = 1'b1;
					dec_vec     = {3'h0, exc_vector};
				end
			end else if (nmi_event) begin
				if (ctrl_r.nmi_exiting || ctrl_r.virtual_nmi) begin
					dec_exit = 1'b1;
				end else if (!live_r.nmi_blk) begin
					dec_deliver = 1'b1;
					dec_nmi_dlv = 1'b1;
					dec_vec     = gevx_pkg::GEVX_NMI_VECTOR;
				end
			end else if (ext_int_pending && ctrl_r.ext_int_exiting) begin
				dec_exit = 1'b1;
				dec_ext  = 1'b1;
				dec_ack  = ctrl_r.ack_on_exit;
				dec_rsn  = gevx_pkg::GEVX_RSN_EXT_INT;
			end else if (ext_int_pending && guest_interrupt_enable_flag
				&& !live_r.ei_shadow_blk && !live_r.ss_load_blk) begin
				dec_guest_ack = 1'b1;
			end else if (ctrl_r.nmi_window_exiting && ctrl_r.virtual_nmi
				&& !live_r.nmi_blk) begin
				dec_exit = 1'b1;
				dec_rsn  = gevx_pkg::GEVX_RSN_NMI_WIN;
			end
		end
	end

	// ---------------------------------------------------------------
	// Mode and acknowledge sequencing
	// ---------------------------------------------------------------

	// Entry only from host; an ack cycle finishes before anything else
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r   <= ST_HOST;
			ack_tgt_r <= gevx_pkg::GEVX_ACK_GUEST;
		end else begin
			case (state_r)
				ST_HOST: begin
					if (entry_cmd) begin
						state_r <= ST_GUEST;
					end else if (host_if_r && ext_int_pending) begin
						state_r   <= ST_ACK;
						ack_tgt_r <= gevx_pkg::GEVX_ACK_HOST;
					end
				end
				ST_GUEST: begin
					if (dec_exit && dec_ack) begin
						state_r   <= ST_ACK;
						ack_tgt_r <= gevx_pkg::GEVX_ACK_EXIT;
					end else if (dec_exit) begin
						state_r <= ST_HOST;
					end else if (dec_guest_ack) begin
						state_r   <= ST_ACK;
						ack_tgt_r <= gevx_pkg::GEVX_ACK_GUEST;
					end
				end
				ST_ACK: begin
					if (intack_done) begin
						state_r <= (ack_tgt_r == gevx_pkg::GEVX_ACK_GUEST) ? ST_GUEST : ST_HOST;
					end
				end
				default: state_r <= ST_HOST;
			endcase
		end
	end

	// Request held until the controller returns the vector
	assign intack_req = (state_r == ST_ACK);

	// Exit pulse, reason and interruption information
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			vm_exit_r   <= 1'b0;
			exit_rsn_r  <= gevx_pkg::GEVX_RSN_EXC_NMI;
			exit_info_r <= gevx_pkg::GEVX_RST_WORD;
		end else begin
			vm_exit_r <= 1'b0;
			if (state_r == ST_GUEST && dec_exit && !dec_ack) begin
				vm_exit_r   <= 1'b1;
				exit_rsn_r  <= dec_rsn;
				exit_info_r <= gevx_pkg::GEVX_RST_WORD;
			end else if (state_r == ST_ACK && intack_done
				&& ack_tgt_r == gevx_pkg::GEVX_ACK_EXIT) begin
				vm_exit_r   <= 1'b1;
				exit_rsn_r  <= gevx_pkg::GEVX_RSN_EXT_INT;
				exit_info_r <= {1'b1, 23'h0, intack_vector};
			end
		end
	end

	// Host flag: cleared on ext exit and when host vectoring starts
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			host_if_r <= 1'b0;
		end else if (state_r == ST_GUEST && dec_ext) begin
			host_if_r <= 1'b0;
		end else if (state_r == ST_HOST && host_if_r && ext_int_pending && !entry_cmd) begin
			host_if_r <= 1'b0;
		end else if (hostif_cmd) begin
			host_if_r <= 1'b1;
		end
	end

	// Guest and host vectoring pulses
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			deliver_r     <= 1'b0;
			deliver_vec_r <= 8'h00;
			host_vec_v_r  <= 1'b0;
			host_vec_r    <= 8'h00;
		end else begin
			deliver_r    <= 1'b0;
			host_vec_v_r <= 1'b0;
			if (dec_deliver) begin
				deliver_r     <= 1'b1;
				deliver_vec_r <= dec_vec;
			end else if (state_r == ST_ACK && intack_done
				&& ack_tgt_r == gevx_pkg::GEVX_ACK_GUEST) begin
				deliver_r     <= 1'b1;
				deliver_vec_r <= intack_vector;
			end
			if (state_r == ST_ACK && intack_done && ack_tgt_r == gevx_pkg::GEVX_ACK_HOST) begin
				host_vec_v_r <= 1'b1;
				host_vec_r   <= intack_vector;
			end
		end
	end

	// ---------------------------------------------------------------
	// Interruptibility tracking
	// ---------------------------------------------------------------

	// Loaded at entry; a set wins over a clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			live_r <= '0;
		end else if (entry_cmd && state_r == ST_HOST) begin
			live_r <= gst_intr_r;
		end else if (state_r != ST_HOST) begin
			if (enable_interrupts_instr) begin
				live_r.ei_shadow_blk <= 1'b1;
			end else if (instr_retire) begin
				live_r.ei_shadow_blk <= 1'b0;
			end
			if (stack_segment_load_instr) begin
				live_r.ss_load_blk <= 1'b1;
			end else if (instr_retire) begin
				live_r.ss_load_blk <= 1'b0;
			end
			if (system_mgmt_interrupt) begin
				live_r.mgmt_blk <= 1'b1;
			end else if (mgmt_mode_resume_instr) begin
				live_r.mgmt_blk <= 1'b0;
			end
			if (dec_nmi_dlv) begin
				live_r.nmi_blk <= 1'b1;
			end else if (interrupt_return_instr || mgmt_mode_resume_instr) begin
				live_r.nmi_blk <= 1'b0;
			end
		end
	end

	// Outputs
	assign vm_exit           = vm_exit_r;
	assign guest_deliver     = deliver_r;
	assign deliver_vector    = deliver_vec_r;
	assign host_vector_valid = host_vec_v_r;
	assign host_vector       = host_vec_r;
	assign host_if_flag      = host_if_r;
	assign guest_mode        = (state_r != ST_HOST);
	assign init_blocked      = (state_r == ST_HOST) || system_mgmt_mode;
	assign startup_ipi_blocked = (state_r == ST_HOST);

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_guest_quiet;
		state_r == ST_GUEST && !init_event && !startup_ipi_event;
	endsequence

	sequence s_ack_exit_done;
		state_r == ST_ACK && ack_tgt_r == gevx_pkg::GEVX_ACK_EXIT && intack_done;
	endsequence

	chk_init_exit: assert property (state_r == ST_GUEST && init_event
		|=> vm_exit && exit_rsn_r == gevx_pkg::GEVX_RSN_INIT ##1 !guest_mode)
		else $error("init in guest did not exit");

	chk_bitmap_exit: assert property (s_guest_quiet ##0 exc_valid
		&& exc_vector != 5'(gevx_pkg::GEVX_PF_VECTOR) && bmap_r[exc_vector]
		|=> vm_exit && !guest_deliver)
		else $error("selected exception did not exit");

	chk_exc_deliver: assert property (s_guest_quiet ##0 exc_valid && !exc_in_df
		&& exc_vector != 5'(gevx_pkg::GEVX_PF_VECTOR) && !bmap_r[exc_vector]
		|=> guest_deliver && deliver_vector == {3'h0, $past(exc_vector)})
		else $error("unselected exception not delivered");

	chk_exit_excl: assert property (!(vm_exit && guest_deliver))
		else $error("event both exited and delivered");

	chk_ack_vector: assert property (s_ack_exit_done |=> vm_exit
		&& exit_info_r == {1'b1, 23'h0, $past(intack_vector)}
		&& exit_rsn_r == gevx_pkg::GEVX_RSN_EXT_INT)
		else $error("acked vector not recorded");

	chk_no_ack: assert property (s_guest_quiet ##0 dec_ext && !ctrl_r.ack_on_exit
		|=> !intack_req[*2] ##0 exit_info_r == 32'h0000_0000)
		else $error("ack ran with ack on exit clear");

	chk_hostif_clear: assert property (vm_exit && exit_rsn_r == gevx_pkg::GEVX_RSN_EXT_INT
		|-> !host_if_flag)
		else $error("host flag left set after ext exit");

	chk_host_block: assert property (!guest_mode |-> init_blocked && startup_ipi_blocked
		##1 !vm_exit)
		else $error("init or startup not blocked in host");

	chk_intr_save: assert property (vm_exit |=> gst_intr_r == $past(live_r))
		else $error("interruptibility not saved on exit");

	chk_ei_shadow: assert property (state_r == ST_GUEST && enable_interrupts_instr
		|=> live_r.ei_shadow_blk)
		else $error("enable shadow blocking not recorded");

endmodule : gevx_core

// [common/gevx_pkg.sv]
// Purpose : Shared constants and carriers for the guest event exit control block
// Assumes : APB slave with 32-bit data, byte addresses on paddr[7:0]
// Notes   : Every register offset and CMD bit position used by the core lives here; STATUS field positions are fixed in the core

package gevx_pkg;

	// ---------------------------------------------------------------
	// Register map (byte addresses)
	// ---------------------------------------------------------------
	localparam logic [7:0] GEVX_OFF_CTRL      = 8'h00;
	localparam logic [7:0] GEVX_OFF_EXC_BMAP  = 8'h04;
	localparam logic [7:0] GEVX_OFF_PF_MASK   = 8'h08;
	localparam logic [7:0] GEVX_OFF_PF_MATCH  = 8'h0C;
	localparam logic [7:0] GEVX_OFF_GST_INTR  = 8'h10;
	localparam logic [7:0] GEVX_OFF_CMD       = 8'h14;
	localparam logic [7:0] GEVX_OFF_STATUS    = 8'h18;
	localparam logic [7:0] GEVX_OFF_EXIT_RSN  = 8'h1C;
	localparam logic [7:0] GEVX_OFF_EXIT_INFO = 8'h20;
	localparam logic [7:0] GEVX_OFF_LIVE_INTR = 8'h24;

	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int GEVX_CMD_ENTRY_BIT   = 0;
	localparam int GEVX_CMD_HOSTIF_BIT  = 1;
	localparam int GEVX_INFO_VALID_BIT  = 31;
	localparam int GEVX_PF_VECTOR       = 14;

	// ---------------------------------------------------------------
	// Reset values and fixed vectors
	// ---------------------------------------------------------------
	localparam logic [31:0] GEVX_RST_WORD   = 32'h0000_0000;
	localparam logic [7:0]  GEVX_NMI_VECTOR = 8'h02;

	// ---------------------------------------------------------------
	// Basic exit reasons
	// ---------------------------------------------------------------
	localparam logic [15:0] GEVX_RSN_EXC_NMI = 16'h0000;
	localparam logic [15:0] GEVX_RSN_EXT_INT = 16'h0001;
	localparam logic [15:0] GEVX_RSN_TRIPLE  = 16'h0002;
	localparam logic [15:0] GEVX_RSN_INIT    = 16'h0003;
	localparam logic [15:0] GEVX_RSN_STARTUP = 16'h0004;
	localparam logic [15:0] GEVX_RSN_NMI_WIN = 16'h0008;

	// Execution controls, CTRL register bits [4:0]
	typedef struct packed {
		logic ack_on_exit;
		logic nmi_window_exiting;
		logic virtual_nmi;
		logic nmi_exiting;
		logic ext_int_exiting;
	} gevx_ctrl_t;

	// Interruptibility state, bits [3:0]
	typedef struct packed {
		logic nmi_blk;
		logic mgmt_blk;
		logic ss_load_blk;
		logic ei_shadow_blk;
	} gevx_intr_t;

	typedef enum logic [1:0] {
		GEVX_ACK_GUEST,
		GEVX_ACK_EXIT,
		GEVX_ACK_HOST
	} gevx_ack_tgt_t;

endpackage : gevx_pkg

// [sim/gevx_intc_model.sv]
// Purpose : Interrupt controller model facing the acknowledge port
// Assumes : One interrupt outstanding at a time
// Notes   : Vector lines toggle when no answer is driven
`timescale 1ns/100ps

module gevx_intc_model (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       raise,
	input  wire logic [7:0] raise_vector,
	input  wire logic       slow,
	input  wire logic       intack_req,
	output logic            ext_int_pending,
	output logic            intack_done,
	output logic      [7:0] intack_vector
);
	logic [7:0] vec_r;
	logic [2:0] wait_r;

	// ---------------------------------------------------------------
	// Pending level and acknowledge answer
	// ---------------------------------------------------------------
	// Pending holds until acknowledged, so an exit without ack leaves it queued
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_int_pending <= 1'h0;
			intack_done     <= 1'h0;
			intack_vector   <= 8'hFF;
			vec_r           <= 8'h00;
			wait_r          <= 3'h0;
		end else begin
			intack_done   <= 1'h0;
			intack_vector <= ~intack_vector; // No stale vector between answers
			if (raise) begin
				ext_int_pending <= 1'h1;
				vec_r           <= raise_vector;
			end else if (ext_int_pending && intack_req && !intack_done) begin
				if (wait_r == (slow ? 3'h4 : 3'h0)) begin
					intack_done     <= 1'h1;
					intack_vector   <= vec_r;
					ext_int_pending <= 1'h0;
					wait_r          <= 3'h0;
				end else begin
					wait_r <= wait_r + 3'h1;
				end
			end
		end
	end
endmodule : gevx_intc_model

// [sim/guest_event_exit_control_bench.sv]
// Purpose : Self-checking bench for the guest event exit core
// Assumes : Controller model answers acknowledge cycles
// Notes   : Random values from a fixed-seed shift register
`timescale 1ns/100ps
`define CHK(nm, ex, gt) begin checks_done++; if ((gt) !== (ex)) begin err_count++; \
	$display("CHECK FAILED %s expected %h seen %h", nm, ex, gt); end end

module guest_event_exit_control_bench;
	// ---------------------------------------------------------------
	// Signals
	// ---------------------------------------------------------------
	logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic [7:0] paddr = 8'h00, irq_vec = 8'h00, v, intack_vector, deliver_vector;
	logic [7:0] host_vector, got_v;
	logic [31:0] pwdata = 32'h0, exc_err_code = 32'h0, prdata, rd_q, s, bm, pfm, pfc, pft;
	logic [4:0] exc_vector = 5'h00, vec;
	logic exc_valid = 1'h0, exc_in_df = 1'h0, guest_interrupt_enable_flag = 1'h0;
	logic system_mgmt_mode = 1'h0, instr_retire = 1'h0, enable_interrupts_instr = 1'h0;
	logic stack_segment_load_instr = 1'h0, interrupt_return_instr = 1'h0;
	logic mgmt_mode_resume_instr = 1'h0, system_mgmt_interrupt = 1'h0, nmi_event = 1'h0;
	logic init_event = 1'h0, startup_ipi_event = 1'h0, irq_raise = 1'h0, irq_slow = 1'h0;
	logic pready, pslverr, ext_int_pending, intack_req, intack_done, vm_exit, guest_deliver;
	logic host_vector_valid, host_if_flag, guest_mode, init_blocked, startup_ipi_blocked;
	logic err_q, got_x, got_d, ex;
	logic [4:0] vt [4] = '{5'h03, 5'h04, 5'h05, 5'h0E};
	logic [31:0] ct [3] = '{32'h02, 32'h04, 32'h00};
	int err_count = 0, checks_done = 0;

	// 20 MHz clock
	always #25 pclk = ~pclk;

	gevx_core gevx_core_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .exc_valid, .exc_vector, .exc_err_code, .exc_in_df,
		.guest_interrupt_enable_flag, .system_mgmt_mode, .instr_retire,
		.enable_interrupts_instr, .stack_segment_load_instr, .interrupt_return_instr,
		.mgmt_mode_resume_instr, .system_mgmt_interrupt, .nmi_event, .init_event,
		.startup_ipi_event, .ext_int_pending, .intack_req, .intack_done, .intack_vector,
		.vm_exit, .guest_deliver, .deliver_vector, .host_vector_valid, .host_vector,
		.host_if_flag, .guest_mode, .init_blocked, .startup_ipi_blocked);
	gevx_intc_model gevx_intc_model_inst (.pclk, .presetn, .raise(irq_raise),
		.raise_vector(irq_vec), .slow(irq_slow), .intack_req, .ext_int_pending,
		.intack_done, .intack_vector);

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr

	// Page faults exit when the bitmap bit equals the mask/match outcome
	function automatic logic exp_exit(input logic [31:0] b, c, m, t, input logic [4:0] e);
		return (e == 5'(gevx_pkg::GEVX_PF_VECTOR)) ? (b[e] == ((c & m) == t)) : b[e];
	endfunction : exp_exit

	task automatic wrap_up();
		$display("Comparisons %0d, mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : wrap_up

	// Request holds until pready is sampled high; data is taken at that edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'h1 && n < 20);
		rd_q = prdata;
		err_q = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		if (n >= 20) begin
			err_count++;
			wrap_up();
		end
	endtask : apb

	task automatic fire(input int k);
		@(posedge pclk);
		case (k)
			0: exc_valid <= 1'h1;
			1: nmi_event <= 1'h1;
			2: init_event <= 1'h1;
			3: startup_ipi_event <= 1'h1;
			4: enable_interrupts_instr <= 1'h1;
			5: interrupt_return_instr <= 1'h1;
			6: stack_segment_load_instr <= 1'h1;
			default: mgmt_mode_resume_instr <= 1'h1;
		endcase
		@(posedge pclk);
		{exc_valid, nmi_event, init_event, startup_ipi_event} <= 4'h0;
		{enable_interrupts_instr, interrupt_return_instr} <= 2'h0;
		{stack_segment_load_instr, mgmt_mode_resume_instr} <= 2'h0;
	endtask : fire

	task automatic watch(input int lim);
		got_x = 1'h0;
		got_d = 1'h0;
		for (int n = 0; n < lim && !got_x && !got_d; n++) begin
			@(negedge pclk);
			got_x = (vm_exit === 1'h1);
			got_d = (guest_deliver === 1'h1);
			got_v = deliver_vector;
		end
	endtask : watch

	task automatic raise(input logic [7:0] x, input logic sl);
		@(posedge pclk);
		irq_vec <= x;
		irq_slow <= sl;
		irq_raise <= 1'h1;
		@(posedge pclk);
		irq_raise <= 1'h0;
	endtask : raise

	task automatic enter();
		apb(1'h1, gevx_pkg::GEVX_OFF_CMD, 32'h1);
		@(negedge pclk);
		`CHK("guest", 1'h1, guest_mode);
	endtask : enter

	task automatic reason(input logic [15:0] r);
		apb(1'h0, gevx_pkg::GEVX_OFF_EXIT_RSN, 32'h0);
		`CHK("reason", r, rd_q[15:0]);
	endtask : reason

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		s = 32'h2007EA7A;
		repeat (8) @(posedge pclk);
		presetn <= 1'h1;
		@(negedge pclk);
		`CHK("init blk", 1'h1, init_blocked);
		`CHK("ipi blk", 1'h1, startup_ipi_blocked);
		apb(1'h0, 8'h40, 32'h0);
		`CHK("unmapped", 33'h1_0000_0000, {err_q, rd_q});
		fire(2);
		watch(6);
		`CHK("host init", 1'h0, got_x);
		enter();
		`CHK("init open", 2'h0, {init_blocked, startup_ipi_blocked});
		@(posedge pclk);
		system_mgmt_mode <= 1'h1;
		@(negedge pclk);
		`CHK("init mgmt", 1'h1, init_blocked);
		@(posedge pclk);
		system_mgmt_mode <= 1'h0;
		for (int k = 2; k < 4; k++) begin
			if (k == 3) enter();
			fire(k);
			watch(6);
			`CHK("always exit", 1'h1, got_x);
			reason(k == 2 ? gevx_pkg::GEVX_RSN_INIT : gevx_pkg::GEVX_RSN_STARTUP);
		end
		// Exceptions with random bitmap, page-fault mask and match
		for (int i = 0; i < 12; i++) begin
			s = lfsr(s);
			bm = s;
			s = lfsr(s);
			vec = (i < 4) ? vt[i] : s[4:0];
			pfm = 32'(s[11:8]);
			pfc = 32'(s[15:12]);
			pft = 32'(s[19:16]);
			apb(1'h1, gevx_pkg::GEVX_OFF_EXC_BMAP, bm);
			apb(1'h1, gevx_pkg::GEVX_OFF_PF_MASK, pfm);
			apb(1'h1, gevx_pkg::GEVX_OFF_PF_MATCH, pft);
			exc_vector <= vec;
			exc_err_code <= pfc;
			enter();
			fire(0);
			watch(6);
			ex = exp_exit(bm, pfc, pfm, pft, vec);
			`CHK("exc exit", ex, got_x);
			`CHK("exc both", 1'h0, got_x & got_d);
			if (ex) reason(gevx_pkg::GEVX_RSN_EXC_NMI);
			else begin
				`CHK("exc vec", {3'h0, vec}, got_v);
				fire(2);
				watch(6);
			end
		end
		apb(1'h1, gevx_pkg::GEVX_OFF_EXC_BMAP, 32'h0);
		exc_vector <= 5'h0D;
		exc_in_df <= 1'h1;
		enter();
		fire(0);
		watch(6);
		`CHK("triple", 1'h1, got_x);
		reason(gevx_pkg::GEVX_RSN_TRIPLE);
		exc_in_df <= 1'h0;
		// Blocking state loaded on entry, tracked, saved on exit
		apb(1'h1, gevx_pkg::GEVX_OFF_GST_INTR, 32'h4);
		enter();
		apb(1'h0, gevx_pkg::GEVX_OFF_LIVE_INTR, 32'h0);
		`CHK("live load", 4'h4, rd_q[3:0]);
		fire(4);
		fire(6);
		fire(7);
		apb(1'h0, gevx_pkg::GEVX_OFF_LIVE_INTR, 32'h0);
		`CHK("live blk", 4'h3, rd_q[3:0]);
		fire(2);
		watch(6);
		apb(1'h0, gevx_pkg::GEVX_OFF_GST_INTR, 32'h0);
		`CHK("saved", 4'h3, rd_q[3:0]);
		apb(1'h1, gevx_pkg::GEVX_OFF_GST_INTR, 32'h0);
		for (int j = 0; j < 3; j++) begin
			apb(1'h1, gevx_pkg::GEVX_OFF_CTRL, ct[j]);
			enter();
			fire(1);
			watch(6);
			`CHK("nmi exit", (j < 2), got_x);
			if (j < 2) reason(gevx_pkg::GEVX_RSN_EXC_NMI);
			else begin
				`CHK("nmi vec", gevx_pkg::GEVX_NMI_VECTOR, got_v);
				fire(2);
				watch(6);
			end
		end
		// Window exit only once the return clears blocking
		apb(1'h1, gevx_pkg::GEVX_OFF_GST_INTR, 32'h8);
		apb(1'h1, gevx_pkg::GEVX_OFF_CTRL, 32'h0C);
		enter();
		watch(6);
		`CHK("win early", 1'h0, got_x);
		fire(5);
		watch(6);
		`CHK("win exit", 1'h1, got_x);
		reason(gevx_pkg::GEVX_RSN_NMI_WIN);
		apb(1'h1, gevx_pkg::GEVX_OFF_GST_INTR, 32'h0);
		// External interrupts: ack exit, plain exit, guest delivery
		apb(1'h1, gevx_pkg::GEVX_OFF_CMD, 32'h2);
		apb(1'h1, gevx_pkg::GEVX_OFF_CTRL, 32'h11);
		`CHK("host flag", 1'h1, host_if_flag);
		enter();
		s = lfsr(s);
		v = {1'h1, s[6:0]};
		raise(v, 1'h1);
		watch(30);
		`CHK("ext exit", 1'h1, got_x);
		reason(gevx_pkg::GEVX_RSN_EXT_INT);
		apb(1'h0, gevx_pkg::GEVX_OFF_EXIT_INFO, 32'h0);
		`CHK("ext info", {1'h1, 23'h0, v}, rd_q);
		`CHK("flag clr", 1'h0, host_if_flag);
		apb(1'h1, gevx_pkg::GEVX_OFF_CTRL, 32'h01);
		enter();
		v = {1'h1, s[14:8]};
		raise(v, 1'h0);
		watch(30);
		reason(gevx_pkg::GEVX_RSN_EXT_INT);
		`CHK("no ack", 2'h2, {ext_int_pending, intack_req});
		apb(1'h1, gevx_pkg::GEVX_OFF_CMD, 32'h2);
		for (int n = 0; n < 30 && host_vector_valid !== 1'h1; n++) @(negedge pclk);
		`CHK("host vec", {1'h1, v}, {host_vector_valid, host_vector});
		apb(1'h1, gevx_pkg::GEVX_OFF_CTRL, 32'h00);
		enter();
		raise({1'h1, s[22:16]}, 1'h1);
		watch(12);
		`CHK("gated", 2'h0, {got_x, got_d});
		@(posedge pclk);
		guest_interrupt_enable_flag <= 1'h1;
		watch(30);
		`CHK("delivered", {1'h1, 1'h1, s[22:16]}, {got_d, got_v});
		wrap_up();
	end
endmodule : guest_event_exit_control_bench
